// File: common/iamr_cfg.svh
// offsets, field positions, reset values and timing counts of the address/mask bank
`ifndef IAMR_CFG_SVH
`define IAMR_CFG_SVH

// register byte offsets
`define IAMR_OFF_ADDR_HIGH 8'h00
`define IAMR_OFF_ADDR_ALIAS 8'h04
`define IAMR_OFF_MASK 8'h08
`define IAMR_OFF_CTRL 8'h0C
`define IAMR_OFF_STAT 8'h10

// address register fields
`define IAMR_UPPER_HI 15
`define IAMR_UPPER_LO 8
`define IAMR_MID_HI 7
`define IAMR_MID_LO 0

// mask register fields
`define IAMR_MISSED_MASK 12
`define IAMR_MEMERR_MASK 11
`define IAMR_RXIRQ_MASK 10
`define IAMR_TXIRQ_MASK 9
`define IAMR_IDONE_MASK 8
`define IAMR_TRANSMIT_UNDERFLOW_ERROR_RECOVER 6
`define IAMR_LOOK_AHEAD 5
`define IAMR_DEFER_DIS 4
`define IAMR_MASK_WRITABLE 16'h1F70
`define IAMR_MASK_RESET 16'h0000

// control register fields
`define IAMR_CTRL_WIDE 0
`define IAMR_CTRL_GLOBAL_IRQ_ENABLE 1
`define IAMR_CTRL_STOP 2
`define IAMR_CTRL_SUSPEND 3
`define IAMR_CTRL_RESET 4'h4

// status register fields
`define IAMR_STAT_SUMMARY 0
`define IAMR_STAT_IRQ 1
`define IAMR_STAT_TRANSMIT_ON_STATUS 2
`define IAMR_STAT_SCAN_LO 4

// axi responses
`define IAMR_RESP_OKAY 2'h0
`define IAMR_RESP_SLVERR 2'h2

// descriptor poll interval
`define IAMR_POLL_NS 1600
`define IAMR_CLK_NS 40
`define IAMR_POLL_CYC (`IAMR_POLL_NS / `IAMR_CLK_NS)

`endif

// File: common/iamr_pkg.sv
// types shared by the address/mask register bank
package iamr_pkg;

    typedef enum logic [2:0] {
        REG_ADDR_HIGH = 3'h0,
        REG_ADDR_ALIAS = 3'h1,
        REG_MASK = 3'h2,
        REG_CTRL = 3'h3,
        REG_STAT = 3'h4,
        REG_NONE = 3'h7
    } iamr_reg_t;

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_WALK = 2'b01,
        SCAN_POLL = 2'b10,
        SCAN_HOLD = 2'b11
    } iamr_scan_t;

endpackage

// File: core/iamr_regs.sv
// init address and interrupt mask register bank with look-ahead descriptor scan
`timescale 1ns/100ps
`include "iamr_cfg.svh"

module iamr_regs
    import iamr_pkg::*;
#(
    parameter int POLL_CYCLES = `IAMR_POLL_CYC
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    // axi4-lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // interrupt status inputs, summary flag and irq output
    input wire logic missedFrameStatus,
    input wire logic memoryErrorStatus,
    input wire logic receiveIrqStatus,
    input wire logic transmitIrqStatus,
    input wire logic initDoneStatus,
    output logic summaryIrqFlag,
    output logic irqRequestOut,
    // address forming
    input wire logic [15:0] initAddrLow,
    input wire logic [31:0] descBaseIn,
    input wire logic [31:0] bufAddrIn,
    output logic [31:0] busInitAddr,
    output logic [31:0] busDescAddr,
    output logic [31:0] busBufAddr,
    // transmit control
    input wire logic txStartReq,
    input wire logic transmitUnderflowError,
    output logic transmitOnStatus,
    output logic txResyncReq,
    output logic twoPartDeferral,
    // receive descriptors
    input wire logic rxFirstDescDone,
    input wire logic rxLastDescDone,
    input wire logic rxFrameArrive,
    input wire logic descAck,
    input wire logic descOwnDev,
    input wire logic descStartOfPacket,
    output logic rxIrqSet,
    output logic rxUseStartBit,
    output logic descReq,
    output logic descClearOwn,
    output logic descAdvance,
    output logic descHeld
);

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] initAddrHigh;
    logic [15:0] maskReg;
    logic [3:0] ctrlReg;
    logic awTaken;
    logic wTaken;
    logic [7:0] awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0] wStrbQ;
    logic doWrite;
    iamr_reg_t wrSel;
    iamr_scan_t scanState;
    iamr_scan_t next_scanState;
    logic [15:0] pollCount;
    logic [4:0] statusVec;
    logic [4:0] maskVec;
    logic next_summary;
    logic wideMode;
    logic addrOpen;
    logic [7:0] upperAddressByte;
    localparam logic [15:0] MASK_KEEP = `IAMR_MASK_WRITABLE;

    function automatic iamr_reg_t regSel(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        case (w)
            `IAMR_OFF_ADDR_HIGH: regSel = REG_ADDR_HIGH;
            `IAMR_OFF_ADDR_ALIAS: regSel = REG_ADDR_ALIAS;
            `IAMR_OFF_MASK: regSel = REG_MASK;
            `IAMR_OFF_CTRL: regSel = REG_CTRL;
            `IAMR_OFF_STAT: regSel = REG_STAT;
            default: regSel = REG_NONE;
        endcase
    endfunction

    // narrow mode replaces the top byte of a 24-bit pointer
    function automatic logic [31:0] formAddr(input logic wide, input logic [7:0] up,
                                             input logic [31:0] raw);
        formAddr = wide ? raw : {up, raw[23:0]};
    endfunction

    assign wideMode = ctrlReg[`IAMR_CTRL_WIDE];
    assign addrOpen = ctrlReg[`IAMR_CTRL_STOP] | ctrlReg[`IAMR_CTRL_SUSPEND];
    assign upperAddressByte = initAddrHigh[`IAMR_UPPER_HI:`IAMR_UPPER_LO];

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channels, either order
    assign awready = ce & ~awTaken & ~bvalid;
    assign wready = ce & ~wTaken & ~bvalid;
    assign doWrite = ce & awTaken & wTaken & ~bvalid;
    assign wrSel = regSel(awAddrQ);

    always_ff @(posedge mclk) begin
        if (srst) begin
            awTaken <= 1'b0;
            wTaken <= 1'b0;
            awAddrQ <= 8'h00;
            wDataQ <= 32'h0000_0000;
            wStrbQ <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `IAMR_RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                awTaken <= 1'b1;
                awAddrQ <= awaddr;
            end
            if (wvalid && wready) begin
                wTaken <= 1'b1;
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end
            if (doWrite) begin
                awTaken <= 1'b0;
                wTaken <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (wrSel == REG_NONE) ? `IAMR_RESP_SLVERR : `IAMR_RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read channel
    assign arready = ce & ~rvalid;

    always_ff @(posedge mclk) begin
        if (srst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `IAMR_RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= `IAMR_RESP_OKAY;
                case (regSel(araddr))
                    REG_ADDR_HIGH, REG_ADDR_ALIAS: rdata <= {16'h0000, initAddrHigh};
                    REG_MASK: rdata <= {16'h0000, maskReg};
                    REG_CTRL: rdata <= {28'h000_0000, ctrlReg};
                    REG_STAT: rdata <= {24'h00_0000, 2'b00, scanState, 1'b0,
                                        transmitOnStatus, irqRequestOut, summaryIrqFlag};
                    default: begin
                        rdata <= 32'h0000_0000;
                        rresp <= `IAMR_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address storage has no reset on purpose: it must survive every reset
    always_ff @(posedge mclk) begin
        if (doWrite && addrOpen && !srst &&
            (wrSel == REG_ADDR_HIGH || wrSel == REG_ADDR_ALIAS)) begin
            if (wStrbQ[0]) begin
                initAddrHigh[7:0] <= wDataQ[7:0];
            end
            if (wStrbQ[1]) begin
                initAddrHigh[15:8] <= wDataQ[15:8];
            end
        end
    end

    // mask register, reserved bits forced to zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            maskReg <= `IAMR_MASK_RESET;
        end else if (doWrite && wrSel == REG_MASK) begin
            if (wStrbQ[0]) begin
                maskReg[7:0] <= wDataQ[7:0] & MASK_KEEP[7:0];
            end
            if (wStrbQ[1]) begin
                maskReg[15:8] <= wDataQ[15:8] & MASK_KEEP[15:8];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrlReg <= `IAMR_CTRL_RESET;
        end else if (doWrite && wrSel == REG_CTRL && wStrbQ[0]) begin
            ctrlReg <= wDataQ[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // summary flag and irq output
    assign statusVec = {missedFrameStatus, memoryErrorStatus, receiveIrqStatus,
                        transmitIrqStatus, initDoneStatus};
    assign maskVec = maskReg[`IAMR_MISSED_MASK:`IAMR_IDONE_MASK];
    assign next_summary = |(statusVec & ~maskVec);

    always_ff @(posedge mclk) begin
        if (srst) begin
            summaryIrqFlag <= 1'b0;
            irqRequestOut <= 1'b0;
        end else if (ce) begin
            summaryIrqFlag <= next_summary;
            irqRequestOut <= next_summary & ctrlReg[`IAMR_CTRL_GLOBAL_IRQ_ENABLE];
        end
    end

    // bus-master addresses
    always_ff @(posedge mclk) begin
        if (srst) begin
            busInitAddr <= 32'h0000_0000;
            busDescAddr <= 32'h0000_0000;
            busBufAddr <= 32'h0000_0000;
        end else if (ce) begin
            busInitAddr <= {initAddrHigh, initAddrLow};
            busDescAddr <= formAddr(wideMode, upperAddressByte, descBaseIn);
            busBufAddr <= formAddr(wideMode, upperAddressByte, bufAddrIn);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter on/off and underflow handling
    always_ff @(posedge mclk) begin
        if (srst) begin
            transmitOnStatus <= 1'b0;
            txResyncReq <= 1'b0;
            twoPartDeferral <= 1'b1;
        end else if (ce) begin
            txResyncReq <= transmitUnderflowError & maskReg[`IAMR_TRANSMIT_UNDERFLOW_ERROR_RECOVER];
            twoPartDeferral <= ~maskReg[`IAMR_DEFER_DIS];
            if (ctrlReg[`IAMR_CTRL_STOP]) begin
                transmitOnStatus <= 1'b0;
            end else if (txStartReq) begin
                transmitOnStatus <= 1'b1;
            end else if (transmitUnderflowError && !maskReg[`IAMR_TRANSMIT_UNDERFLOW_ERROR_RECOVER]) begin
                transmitOnStatus <= 1'b0;
            end
        end
    end

    // receive interrupt pulses
    always_ff @(posedge mclk) begin
        if (srst) begin
            rxIrqSet <= 1'b0;
            rxUseStartBit <= 1'b0;
        end else if (ce) begin
            rxIrqSet <= rxLastDescDone |
                        (rxFirstDescDone & maskReg[`IAMR_LOOK_AHEAD]);
            rxUseStartBit <= maskReg[`IAMR_LOOK_AHEAD];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // look-ahead ring walk after a frame's last descriptor
    always_comb begin
        next_scanState = scanState;
        case (scanState)
            SCAN_IDLE: begin
                if (rxLastDescDone && maskReg[`IAMR_LOOK_AHEAD]) begin
                    next_scanState = SCAN_WALK;
                end
            end
            SCAN_WALK: begin
                if (descAck && descStartOfPacket) begin
                    next_scanState = descOwnDev ? SCAN_HOLD : SCAN_POLL;
                end
            end
            SCAN_POLL: begin
                if (descAck && descStartOfPacket && descOwnDev) begin
                    next_scanState = SCAN_HOLD;
                end
            end
            SCAN_HOLD: begin
                if (rxFrameArrive) begin
                    next_scanState = SCAN_IDLE;
                end
            end
            default: next_scanState = SCAN_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst || ctrlReg[`IAMR_CTRL_STOP]) begin
            scanState <= SCAN_IDLE;
        end else if (ce) begin
            scanState <= next_scanState;
        end
    end

    // poll spacing; a slower poll saves bus bandwidth while the host fills the ring
    always_ff @(posedge mclk) begin
        if (srst) begin
            pollCount <= 16'h0000;
        end else if (ce) begin
            if (scanState != SCAN_POLL || descReq) begin
                pollCount <= 16'h0000;
            end else if (pollCount != 16'(POLL_CYCLES - 1)) begin
                pollCount <= pollCount + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || ctrlReg[`IAMR_CTRL_STOP]) begin
            descReq <= 1'b0;
            descClearOwn <= 1'b0;
            descAdvance <= 1'b0;
            descHeld <= 1'b0;
        end else if (ce) begin
            descClearOwn <= 1'b0;
            descAdvance <= 1'b0;
            descHeld <= (next_scanState == SCAN_HOLD);
            if (descReq && descAck) begin
                descReq <= 1'b0;
                if (scanState == SCAN_WALK && !descStartOfPacket) begin
                    descClearOwn <= descOwnDev;
                    descAdvance <= 1'b1;
                end
            end else if (next_scanState == SCAN_WALK && !descAdvance) begin
                descReq <= 1'b1;
            end else if (scanState == SCAN_POLL && pollCount == 16'(POLL_CYCLES - 1)) begin
                descReq <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    addr_locked_a: assert property (@(posedge mclk) disable iff (srst)
        doWrite && !addrOpen |=> $stable(initAddrHigh))
        else $error("address field changed outside stop or suspend");

    mask_reset_a: assert property (@(posedge mclk) disable iff (srst)
        $fell(srst) |-> maskReg == 16'h0000)
        else $error("mask register not cleared by reset");

    mask_reserved_a: assert property (@(posedge mclk) disable iff (srst)
        maskReg[15:13] == 3'b000 && !maskReg[7])
        else $error("reserved mask bit set");

    summary_gate_a: assert property (@(posedge mclk) disable iff (srst)
        ce |=> summaryIrqFlag == |($past(statusVec) & ~$past(maskVec)))
        else $error("summary flag disagrees with masked status");

    irq_enable_a: assert property (@(posedge mclk) disable iff (srst)
        irqRequestOut |-> summaryIrqFlag && ctrlReg[`IAMR_CTRL_GLOBAL_IRQ_ENABLE] || $changed(ctrlReg))
        else $error("irq output without flag and enable");

    transmit_underflow_error_stop_a: assert property (@(posedge mclk) disable iff (srst)
        ce && transmitUnderflowError && !maskReg[6] && !txStartReq |=> !transmitOnStatus)
        else $error("transmitter not turned off on underflow");

    transmit_underflow_error_recover_a: assert property (@(posedge mclk) disable iff (srst)
        ce && transmitUnderflowError && maskReg[6] |=> txResyncReq ##1 !txResyncReq || ce)
        else $error("underflow recovery not requested");

    first_irq_a: assert property (@(posedge mclk) disable iff (srst)
        ce && rxFirstDescDone && maskReg[5] |=> rxIrqSet)
        else $error("look-ahead first descriptor irq missing");

    clear_own_a: assert property (@(posedge mclk) disable iff (srst)
        ce && scanState == SCAN_WALK && descReq && descAck && !descStartOfPacket
        |=> descAdvance && descClearOwn == $past(descOwnDev))
        else $error("skipped entry not handled");

    host_start_a: assert property (@(posedge mclk) disable iff (srst)
        ce && scanState == SCAN_WALK && descAck && descStartOfPacket && !descOwnDev
        && !ctrlReg[2] |=> scanState == SCAN_POLL && !descAdvance)
        else $error("host-owned start entry not polled");

    narrow_addr_a: assert property (@(posedge mclk) disable iff (srst)
        ce && !wideMode |=> busDescAddr[31:24] === $past(upperAddressByte))
        else $error("upper byte not placed on descriptor address");

    defer_a: assert property (@(posedge mclk) disable iff (srst)
        ce && maskReg[4] |=> !twoPartDeferral)
        else $error("two-part deferral still active");

endmodule

// File: dv/iamr_ring_model.sv
// receive descriptor ring model answering the bank's descriptor fetches
`timescale 1ns/100ps
module iamr_ring_model (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // ring contents and answer delay
    input wire logic [7:0] ownTab,
    input wire logic [7:0] sopTab,
    input wire logic [3:0] ackDelay,
    // descriptor fetch
    input wire logic descReq,
    input wire logic descClearOwn,
    input wire logic descAdvance,
    output logic descAck,
    output logic descOwnDev,
    output logic descStartOfPacket
);
    logic [2:0] ptr;
    logic [3:0] waitCnt;
    logic [7:0] own;
    logic flip;

    always_ff @(posedge mclk) begin
        if (srst) begin
            ptr <= '0;
            waitCnt <= '0;
            descAck <= 1'b0;
            flip <= 1'b0;
            own <= ownTab;
        end else begin
            flip <= ~flip;
            if (descAdvance) begin
                ptr <= ptr + 3'h1;
            end
            if (descClearOwn) begin
                own[ptr] <= 1'b0;
            end
            if (descAck || !descReq) begin
                descAck <= 1'b0;
                waitCnt <= '0;
            end else if (waitCnt == ackDelay) begin
                descAck <= 1'b1;
            end else begin
                waitCnt <= waitCnt + 4'h1;
            end
        end
    end

    // fields mean nothing outside the ack, so they keep changing there
    assign descOwnDev = descAck ? own[ptr] : flip;
    assign descStartOfPacket = descAck ? sopTab[ptr] : ~flip;
endmodule

// File: dv/test_init_addr_and_irq_mask_regs.sv
// self-checking bench for the init address and interrupt mask bank
`timescale 1ns/100ps
`include "iamr_cfg.svh"
module test_init_addr_and_irq_mask_regs;
    logic mclk = 0, srst = 1, ce = 1;
    logic [7:0] awaddr = '0, araddr = '0, ownTab = '0, sopTab = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0, descBaseIn = '0, bufAddrIn = '0, rdata;
    logic [31:0] busInitAddr, busDescAddr, busBufAddr;
    logic [15:0] initAddrLow = '0;
    logic [4:0] stat = '0, pls = '0;
    logic [3:0] ackDelay = '0;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, summaryIrqFlag, irqRequestOut;
    logic transmitOnStatus, txResyncReq, twoPartDeferral, rxIrqSet, rxUseStartBit;
    logic descReq, descClearOwn, descAdvance, descHeld, descAck, descOwnDev, descSop, prevReq;
    int failCount = 0, compares = 0, clrCnt = 0, advCnt = 0, reqRise = 0;

    always #20 mclk = ~mclk;

    iamr_regs #(.POLL_CYCLES(4)) iamr_regs_i (.mclk(mclk), .srst(srst), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .missedFrameStatus(stat[4]), .memoryErrorStatus(stat[3]),
        .receiveIrqStatus(stat[2]), .transmitIrqStatus(stat[1]), .initDoneStatus(stat[0]),
        .summaryIrqFlag(summaryIrqFlag), .irqRequestOut(irqRequestOut),
        .initAddrLow(initAddrLow), .descBaseIn(descBaseIn), .bufAddrIn(bufAddrIn),
        .busInitAddr(busInitAddr), .busDescAddr(busDescAddr), .busBufAddr(busBufAddr),
        .txStartReq(pls[0]), .transmitUnderflowError(pls[1]),
        .transmitOnStatus(transmitOnStatus), .txResyncReq(txResyncReq),
        .twoPartDeferral(twoPartDeferral), .rxFirstDescDone(pls[2]),
        .rxLastDescDone(pls[3]), .rxFrameArrive(pls[4]), .descAck(descAck),
        .descOwnDev(descOwnDev), .descStartOfPacket(descSop), .rxIrqSet(rxIrqSet),
        .rxUseStartBit(rxUseStartBit), .descReq(descReq), .descClearOwn(descClearOwn),
        .descAdvance(descAdvance), .descHeld(descHeld));

    iamr_ring_model iamr_ring_model_i (.mclk(mclk), .srst(srst), .ownTab(ownTab),
        .sopTab(sopTab), .ackDelay(ackDelay), .descReq(descReq), .descClearOwn(descClearOwn),
        .descAdvance(descAdvance), .descAck(descAck), .descOwnDev(descOwnDev),
        .descStartOfPacket(descSop));

    always @(posedge mclk) begin
        prevReq <= descReq;
        if (srst) begin
            clrCnt <= 0;
            advCnt <= 0;
            reqRise <= 0;
        end else begin
            if (descClearOwn) clrCnt <= clrCnt + 1;
            if (descAdvance) advCnt <= advCnt + 1;
            if (descReq && !prevReq) reqRise <= reqRise + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failCount++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rst;
        srst <= 1;
        tick(8);
        srst <= 0;
        tick(1);
    endtask

    // address and data offered together; each released once taken
    // bready and rready stay high between transfers; only the watchdog ends a wait
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
        chk("rdata", rdata, exp);
    endtask

    task automatic pulse(input int b);
        pls[b] <= 1;
        tick(1);
        pls <= '0;
        tick(1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        axr(`IAMR_OFF_MASK, 32'h0000_0000, `IAMR_RESP_OKAY);
        axr(`IAMR_OFF_CTRL, 32'h0000_0004, `IAMR_RESP_OKAY);
        axr(8'h20, 32'h0000_0000, `IAMR_RESP_SLVERR);
        axw(8'h20, 32'h0000_0001, `IAMR_RESP_SLVERR);
        chk("deferral", twoPartDeferral, 1);
    endtask

    task automatic t_addr;
        axw(`IAMR_OFF_CTRL, 32'h0000_0004, `IAMR_RESP_OKAY);
        axw(`IAMR_OFF_ADDR_HIGH, 32'h0000_A5C3, `IAMR_RESP_OKAY);
        initAddrLow <= 16'h1234;
        descBaseIn <= 32'h1122_3344;
        bufAddrIn <= 32'h5566_7788;
        tick(3);
        chk("initAddr", busInitAddr, 32'hA5C3_1234);
        chk("descAddr", busDescAddr, 32'hA522_3344);
        chk("bufAddr", busBufAddr, 32'hA566_7788);
        axr(`IAMR_OFF_ADDR_ALIAS, 32'h0000_A5C3, `IAMR_RESP_OKAY);
        axw(`IAMR_OFF_CTRL, 32'h0000_0005, `IAMR_RESP_OKAY);
        tick(3);
        chk("descAddr", busDescAddr, 32'h1122_3344);
        chk("bufAddr", busBufAddr, 32'h5566_7788);
        chk("initAddr", busInitAddr, 32'hA5C3_1234);
        axw(`IAMR_OFF_ADDR_ALIAS, 32'h0000_5A3C, `IAMR_RESP_OKAY);
        axr(`IAMR_OFF_ADDR_HIGH, 32'h0000_5A3C, `IAMR_RESP_OKAY);
        // with neither stop nor suspend the write is answered but dropped
        axw(`IAMR_OFF_CTRL, 32'h0000_0000, `IAMR_RESP_OKAY);
        axw(`IAMR_OFF_ADDR_HIGH, 32'h0000_FFFF, `IAMR_RESP_OKAY);
        axr(`IAMR_OFF_ADDR_HIGH, 32'h0000_5A3C, `IAMR_RESP_OKAY);
        axw(`IAMR_OFF_CTRL, 32'h0000_0008, `IAMR_RESP_OKAY);
        axw(`IAMR_OFF_ADDR_HIGH, 32'h0000_1111, `IAMR_RESP_OKAY);
        axr(`IAMR_OFF_ADDR_HIGH, 32'h0000_1111, `IAMR_RESP_OKAY);
        rst;
        axr(`IAMR_OFF_ADDR_HIGH, 32'h0000_1111, `IAMR_RESP_OKAY);
    endtask

    task automatic t_mask;
        axw(`IAMR_OFF_CTRL, 32'h0000_0000, `IAMR_RESP_OKAY);
        axw(`IAMR_OFF_MASK, 32'hFFFF_FFFF, `IAMR_RESP_OKAY);
        axr(`IAMR_OFF_MASK, 32'h0000_1F70, `IAMR_RESP_OKAY);
        chk("deferral", twoPartDeferral, 0);
        chk("startBit", rxUseStartBit, 1);
        axw(`IAMR_OFF_CTRL, 32'h0000_0004, `IAMR_RESP_OKAY);
        axr(`IAMR_OFF_MASK, 32'h0000_1F70, `IAMR_RESP_OKAY);
        rst;
        axr(`IAMR_OFF_MASK, 32'h0000_0000, `IAMR_RESP_OKAY);
    endtask

    task automatic t_irq;
        axw(`IAMR_OFF_CTRL, 32'h0000_0002, `IAMR_RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            axw(`IAMR_OFF_MASK, 32'h0000_0000, `IAMR_RESP_OKAY);
            stat <= 5'(1 << i);
            tick(3);
            chk("summary", summaryIrqFlag, 1);
            chk("irqOut", irqRequestOut, 1);
            axw(`IAMR_OFF_MASK, 32'(1 << (8 + i)), `IAMR_RESP_OKAY);
            tick(3);
            chk("summary", summaryIrqFlag, 0);
            chk("irqOut", irqRequestOut, 0);
            stat <= '0;
        end
        axw(`IAMR_OFF_MASK, 32'h0000_0000, `IAMR_RESP_OKAY);
        axw(`IAMR_OFF_CTRL, 32'h0000_0000, `IAMR_RESP_OKAY);
        stat <= 5'h04;
        tick(3);
        chk("irqOut", irqRequestOut, 0);
        // clock enable low must hold the flag although status drops
        ce <= 0;
        stat <= '0;
        tick(3);
        chk("frozen", summaryIrqFlag, 1);
        ce <= 1;
        tick(2);
        chk("summary", summaryIrqFlag, 0);
    endtask

    task automatic t_tx;
        pulse(0);
        chk("transmit_on_status", transmitOnStatus, 1);
        pulse(1);
        chk("transmit_on_status", transmitOnStatus, 0);
        chk("resync", txResyncReq, 0);
        axw(`IAMR_OFF_MASK, 32'h0000_0040, `IAMR_RESP_OKAY);
        pulse(0);
        pulse(1);
        chk("resync", txResyncReq, 1);
        chk("transmit_on_status", transmitOnStatus, 1);
        axw(`IAMR_OFF_MASK, 32'h0000_0000, `IAMR_RESP_OKAY);
        pulse(2);
        chk("rxIrq", rxIrqSet, 0);
        pulse(3);
        chk("rxIrq", rxIrqSet, 1);
        axw(`IAMR_OFF_MASK, 32'h0000_0020, `IAMR_RESP_OKAY);
        pulse(2);
        chk("rxIrq", rxIrqSet, 1);
    endtask

    // ring reloads only at reset, so each search starts from a fresh ring
    task automatic scan(input logic [7:0] o, input logic [7:0] s, input logic [3:0] d);
        ownTab <= o;
        sopTab <= s;
        ackDelay <= d;
        rst;
        axw(`IAMR_OFF_MASK, 32'h0000_0020, `IAMR_RESP_OKAY);
        // reset leaves stop set, which would hold the walk idle
        axw(`IAMR_OFF_CTRL, 32'h0000_0000, `IAMR_RESP_OKAY);
        pulse(3);
    endtask

    task automatic t_scan;
        scan(8'h05, 8'h04, 4'h0);
        while (descHeld !== 1'b1) tick(1);
        chk("cleared", clrCnt, 1);
        chk("advanced", advCnt, 2);
        axr(`IAMR_OFF_STAT, 32'h0000_0030, `IAMR_RESP_OKAY);
        pulse(4);
        tick(2);
        chk("held", descHeld, 0);
        scan(8'h00, 8'h01, 4'h3);
        tick(40);
        chk("polls", 32'(reqRise > 2), 1);
        chk("advanced", advCnt, 0);
        axr(`IAMR_OFF_STAT, 32'h0000_0020, `IAMR_RESP_OKAY);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        rst;
        t_reset;
        t_addr;
        t_mask;
        t_irq;
        t_tx;
        t_scan;
        end_of_test;
    end

    initial begin
        tick(20000);
        failCount++;
        end_of_test;
    end
endmodule
